// ==== testbench/epbpc_asserts.sv ====
// Assertions on the pad enables and driven values
`timescale 1ns/1ps
module epbpc_asserts (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_chip_reset_in_n,
  input wire logic i_hold_req,
  input wire logic i_off_n,
  input wire logic i_wide_host_port_select,
  input wire epbpc_pkg::epbpc_access_t i_access,
  input wire logic [15:0] i_wdata,
  input wire epbpc_pkg::epbpc_addr_pad_t o_ext_addr_bus,
  input wire epbpc_pkg::epbpc_data_pad_t o_ext_data_bus
);
  import epbpc_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic go;
  logic [22:0] aoe;
  logic [15:0] doe;
  assign go = i_access.valid && i_off_n && !i_hold_req && i_chip_reset_in_n;
  assign aoe = o_ext_addr_bus.oe_n;
  assign doe = o_ext_data_bus.oe_n;
  a_off_addr: assert property (!i_off_n |=> &aoe) else $error("addr driven");
  a_off_data: assert property (!i_off_n |=> &doe) else $error("data driven");
  a_hold_addr: assert property (i_hold_req |=> &aoe) else $error("addr in hold");
  a_data_float: assert property (
    !i_chip_reset_in_n || i_hold_req || !(i_access.valid && i_access.write) |=> &doe)
    else $error("data not floated");
  a_upper_addr: assert property (
    !(i_access.valid && i_access.prog_space) |=> &aoe[22:16]) else $error("upper driven");
  a_host_lines: assert property (
    i_wide_host_port_select |=> &aoe[17:0]) else $error("host lines driven");
  a_low_drive: assert property (go && !i_wide_host_port_select |=>
    aoe[15:0] == 16'h0 && o_ext_addr_bus.out[15:0] == $past(i_access.addr[15:0]))
    else $error("low addr wrong");
  a_write_drive: assert property (go && i_access.write |=>
    doe == 16'h0 && o_ext_data_bus.out == $past(i_wdata)) else $error("write data wrong");
  c_write: cover property (go && i_access.write);
  c_prog: cover property (go && i_access.prog_space);
  c_host: cover property (go && i_wide_host_port_select);
endmodule
bind epbpc_top epbpc_asserts u_chk (.i_mclk, .i_rst_n, .i_chip_reset_in_n, .i_hold_req,
  .i_off_n, .i_wide_host_port_select, .i_access, .i_wdata, .o_ext_addr_bus, .o_ext_data_bus);

// ==== testbench/epbpc_ext_mem.sv ====
// Behavioural memory and host resolving the shared pad levels
`timescale 1ns/1ps
module epbpc_ext_mem (
  input wire logic i_mclk,
  input wire epbpc_pkg::epbpc_addr_pad_t i_addr,
  input wire epbpc_pkg::epbpc_data_pad_t i_data,
  input wire logic i_host_en,
  input wire logic [17:0] i_host_addr,
  input wire logic i_mem_drv,
  input wire logic [15:0] i_mem_val,
  input wire logic i_keep,
  output logic [22:0] o_addr_lvl,
  output logic [15:0] o_data_lvl
);
  import epbpc_pkg::*;
  logic [22:0] a_last = '0;
  logic [15:0] d_last = '0;
  logic [22:0] hm;
  always @(posedge i_mclk) {a_last, d_last} <= {o_addr_lvl, o_data_lvl};
  // Unheld data lines flip so a stale value never passes
  always_comb begin
    hm = {5'h0, {18{i_host_en}}};
    o_addr_lvl = (~i_addr.oe_n & i_addr.out) |
      (i_addr.oe_n & ((hm & {5'h0, i_host_addr}) | (~hm & a_last)));
    o_data_lvl = (~i_data.oe_n & i_data.out) |
      (i_data.oe_n & (i_mem_drv ? i_mem_val : i_keep ? d_last : ~d_last));
  end
endmodule

// ==== testbench/ext_parallel_bus_pad_control_tb.sv ====
// Bench for the external bus pad control block
`timescale 1ns/1ps
module ext_parallel_bus_pad_control_tb;
  import epbpc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, crn = 1'b1, hold = 1'b0, off_n = 1'b1, wide = 1'b0;
  logic wr = 1'b0, rd = 1'b0, mdrv = 1'b0, keep = 1'b1;
  logic [15:0] wd = '0, rwd = '0, mval = '0, pw, dl, rdat, pdl, rdo;
  logic hak;
  logic [17:0] ha = '0, ph, hao;
  logic [1:0] ra = '0;
  logic [3:0] pc = '0, qc;
  logic [38:0] e;
  logic [22:0] al;
  epbpc_access_t acc = '0, pa;
  epbpc_addr_pad_t ao;
  epbpc_data_pad_t dq;
  int fails = 0, n_tests = 0;
  always #25 clk = ~clk;
  epbpc_top dut (.i_mclk(clk), .i_rst_n(rst_n), .i_chip_reset_in_n(crn), .i_hold_req(hold),
    .i_off_n(off_n), .i_wide_host_port_select(wide), .i_access(acc), .i_wdata(wd),
    .i_ext_addr_bus_in(al), .i_ext_data_bus_in(dl), .i_reg_addr(ra), .i_reg_wdata(rwd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_ext_addr_bus(ao),
    .o_ext_data_bus(dq), .o_rdata(rdo), .o_host_addr(hao), .o_hold_ack(hak));
  epbpc_ext_mem mem (.i_mclk(clk), .i_addr(ao), .i_data(dq), .i_host_en(wide), .i_host_addr(ha),
    .i_mem_drv(mdrv), .i_mem_val(mval), .i_keep(keep), .o_addr_lvl(al), .o_data_lvl(dl));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bits 38:23 data enables, 22:0 address enables, low = driving
  function automatic logic [38:0] exp_oe(epbpc_access_t a, logic [3:0] c);
    logic go;
    go = a.valid && c[3] && !c[2] && c[1];
    return {{16{!(go && a.write)}},
      ~({{7{go && a.prog_space}}, {16{go}}} & {5'h1f, {18{!c[0]}}})};
  endfunction
  task automatic reg_io(input logic [1:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    {ra, rwd, wr, rd} <= {a, d, w, !w};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    @(negedge clk);
    if (!w) chk(rdat, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9a970990));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    reg_io(2'h0, 1'b0, 16'h0001);
    reg_io(2'h1, 1'b0, 16'h0001);
    @(posedge clk);
    {acc, wd} <= {23'h7abcde, 3'h7, 16'ha5c3};
    @(posedge clk);
    acc <= '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(ao.out, 23'h7abcde);
    chk(dq.out, 16'ha5c3);
    reg_io(2'h0, 1'b1, 16'h0000);
    reg_io(2'h0, 1'b0, 16'h0000);
    keep <= 1'b0;
    repeat (2) @(negedge clk);
    chk(dq.out, 16'h0000);
    reg_io(2'h0, 1'b1, 16'h0001);
    keep <= 1'b1;
    repeat (400) begin
      @(posedge clk);
      {qc, pa, pw, ph, pc} = {pc, acc, wd, ha, crn, hold, off_n, wide};
      pdl = dl;
      {acc, wd, ha, mval} <= {26'($urandom), 16'($urandom), 18'($urandom), 16'($urandom)};
      {crn, hold, off_n, wide, mdrv} <= {$urandom % 8 != 0, $urandom % 6 == 0,
        $urandom % 8 != 0, $urandom % 4 == 0, 1'($urandom)};
      @(negedge clk);
      e = exp_oe(pa, pc);
      chk({dq.oe_n, ao.oe_n}, e);
      if (!e[23]) chk(dq.out, pw);
      if (!e[0]) chk(ao.out[15:0], pa.addr[15:0]);
      if (pc[0] && qc[0]) chk(hao, ph);
      chk(rdo, pdl);
      chk(hak, pc[1] && pc[2]);
    end
    results();
  end
  initial begin
    #60000;
    fails++;
    results();
  end
endmodule

// ==== verilog/epbpc_defines.svh ====
// Constants for the external parallel bus pad control block
`ifndef EPBPC_DEFINES_SVH
`define EPBPC_DEFINES_SVH
`define EPBPC_ADDR_W 23
`define EPBPC_ADDR_LO_W 16
`define EPBPC_HOST_ADDR_W 18
`define EPBPC_DATA_W 16
`define EPBPC_REG_W 16
`define EPBPC_OFS_BANK_CTRL 2'h0
`define EPBPC_OFS_STATUS 2'h1
`define EPBPC_BIT_HOLD_EN 0
`define EPBPC_RST_BANK_CTRL 16'h0001
`endif

// ==== verilog/epbpc_pkg.sv ====
// Types for the external parallel bus pad control block
package epbpc_pkg;
  typedef enum logic [2:0] {
    EPBPC_IDLE = 3'b001,
    EPBPC_HOLD = 3'b010,
    EPBPC_FLOAT = 3'b100
  } epbpc_state_t;
  typedef struct packed {
    logic [22:0] addr;
    logic prog_space;
    logic write;
    logic valid;
  } epbpc_access_t;
  typedef struct packed {
    logic [22:0] out;
    logic [22:0] oe_n;
  } epbpc_addr_pad_t;
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe_n;
  } epbpc_data_pad_t;
endpackage

// ==== verilog/epbpc_top.sv ====
// Pad control of the external address and data buses with bus holders
// Function
// - 23-bit address bus, bit 22 MSB
// - Low 16 address lines for every access
// - Upper seven lines only for program space
// - Hold mode floats all address outputs
// - Output-float input low floats address outputs
// - Wide host mode: address 0-17 are inputs
// - Address bus holder keeps previous level
// - 16-bit bidirectional data bus, bit 15 MSB
// - Data bus shared with host port
// - Data driven only when writing outside reset and hold
// - Output-float low forces data float
// - Data bus holder keeps last level
// - Software bit enables data bus holders
`timescale 1ns/1ps
`include "epbpc_defines.svh"
module epbpc_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_chip_reset_in_n,
  input wire logic i_hold_req,
  input wire logic i_off_n,
  input wire logic i_wide_host_port_select,
  input wire epbpc_pkg::epbpc_access_t i_access,
  input wire logic [15:0] i_wdata,
  input wire logic [22:0] i_ext_addr_bus_in,
  input wire logic [15:0] i_ext_data_bus_in,
  input wire logic [1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  output epbpc_pkg::epbpc_addr_pad_t o_ext_addr_bus,
  output epbpc_pkg::epbpc_data_pad_t o_ext_data_bus,
  output logic [15:0] o_rdata,
  output logic [17:0] o_host_addr,
  output logic o_hold_ack
);
  import epbpc_pkg::*;

  epbpc_state_t state;
  epbpc_state_t next_state;
  logic [15:0] bank_switch_ctrl_reg;
  logic [22:0] addr_hold;
  logic [15:0] data_hold;
  logic [22:0] next_addr_oe_n;
  logic [15:0] next_data_oe_n;
  logic [22:0] next_addr_out;
  logic data_holder_en;

  assign data_holder_en = bank_switch_ctrl_reg[`EPBPC_BIT_HOLD_EN];

  // Holder level: driven value while driving, pad value otherwise
  function automatic logic [15:0] epbpc_keep16(input logic [15:0] drv, input logic [15:0] oe_n,
                                               input logic [15:0] pad);
    epbpc_keep16 = (drv & ~oe_n) | (pad & oe_n);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus ownership state
  always_comb begin
    case (state)
      EPBPC_IDLE: next_state = EPBPC_IDLE;
      EPBPC_HOLD: next_state = EPBPC_HOLD;
      EPBPC_FLOAT: next_state = EPBPC_FLOAT;
      default: next_state = EPBPC_IDLE;
    endcase
    if (!i_off_n) begin
      next_state = EPBPC_FLOAT;
    end else if (i_hold_req) begin
      next_state = EPBPC_HOLD;
    end else begin
      next_state = EPBPC_IDLE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= EPBPC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address pad enables
  always_comb begin
    next_addr_oe_n = '1;
    next_addr_out = addr_hold;
    if (next_state == EPBPC_IDLE && i_chip_reset_in_n && i_access.valid) begin
      next_addr_oe_n[15:0] = 16'h0000;
      next_addr_out[15:0] = i_access.addr[15:0];
      if (i_access.prog_space) begin
        next_addr_oe_n[22:16] = 7'h00;
        next_addr_out[22:16] = i_access.addr[22:16];
      end
    end
    if (i_wide_host_port_select) begin
      next_addr_oe_n[17:0] = 18'h3ffff;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_addr_bus <= '{out: 23'h000000, oe_n: 23'h7fffff};
    end else begin
      o_ext_addr_bus.oe_n <= next_addr_oe_n;
      o_ext_addr_bus.out <= next_addr_out;
    end
  end

  // Address holder always active; floated lines track the pad level
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_hold <= 23'h000000;
    end else begin
      addr_hold <= (o_ext_addr_bus.out & ~o_ext_addr_bus.oe_n)
                 | (i_ext_addr_bus_in & o_ext_addr_bus.oe_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pad enables
  always_comb begin
    next_data_oe_n = 16'hffff;
    if (next_state == EPBPC_IDLE && i_chip_reset_in_n && i_access.valid
        && i_access.write) begin
      next_data_oe_n = 16'h0000;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_data_bus <= '{out: 16'h0000, oe_n: 16'hffff};
    end else begin
      o_ext_data_bus.oe_n <= next_data_oe_n;
      o_ext_data_bus.out <= (next_data_oe_n == 16'h0000) ? i_wdata : data_hold;
    end
  end

  // Holder disabled: last level is not kept, out returns to zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_hold <= 16'h0000;
    end else if (data_holder_en) begin
      data_hold <= epbpc_keep16(o_ext_data_bus.out, o_ext_data_bus.oe_n,
                                i_ext_data_bus_in);
    end else begin
      data_hold <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs: sampled core read data and host-port address, plus hold acknowledge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
      o_host_addr <= 18'h00000;
      o_hold_ack <= 1'b0;
    end else begin
      o_rdata <= i_ext_data_bus_in;
      o_host_addr <= i_wide_host_port_select ? i_ext_addr_bus_in[17:0] : 18'h00000;
      o_hold_ack <= (next_state == EPBPC_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bank_switch_ctrl_reg <= `EPBPC_RST_BANK_CTRL;
    end else if (i_reg_wr && i_reg_addr == `EPBPC_OFS_BANK_CTRL) begin
      bank_switch_ctrl_reg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `EPBPC_OFS_BANK_CTRL: o_reg_rdata <= bank_switch_ctrl_reg;
        `EPBPC_OFS_STATUS: o_reg_rdata <= {13'h0000, state};
        default: o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end
endmodule
